// file: src/tpsg_sound_gen.sv
// Purpose: tone/pwm sound generator with auto attenuator, ahb-lite slave
// Assumes: generator clock is REF_CLK_IN, word accesses only
// Notes: zero-wait-state slave, every response okay
// Operation
// - eight-bit loudness duty, reset zero, read/write
// - output combines pwm pulse with square tone
// - divider writes ignored unless unlock bit set
// - reference divider divides clock, values 1..255
// - tone equals reference over twice pitch divider
// - run request enables regardless of stop confirm
// - output starts after register writes complete
// - attenuator off, mode zero: run request rules
// - attenuator off, mode one: stop confirm stops
// - attenuator on, mode zero: stop immediately
// - attenuator on, mode one: stop after done
// - duty shrinks by 1/32 each attenuation cycle
// - completion sets done flag, gated interrupt request
// - mode zero sets done only on first completion
// - flag cleared mid attenuation sets again later
// - reset holds module stop, registers then closed
// - cycle select: off, tone over 1..32, 7 prohibited
// - done cleared by write zero after read, duty write
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module tpsg_sound_gen
(
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RESETN_IN,
    // ahb-lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic HREADYOUT_OUT,
    output logic [31:0] HRDATA_OUT,
    output logic HRESP_OUT,
    // sound and interrupt
    output logic SOUND_OUT,
    output logic ATTEN_IRQ_OUT
);

    tpsg_pkg::tpsg_state_type s_reg;
    tpsg_pkg::tpsg_state_type s_next;
    logic a_phase;
    logic dp_wr;
    logic ref_tick;
    logic pitch_tick;
    logic atk;
    logic done_evt;
    logic done_clr;

    // floor of d * 31 / 32
    function automatic logic [7:0] decay(input logic [7:0] d);
        logic [12:0] p;
        p = {5'h00, d} * tpsg_pkg::DECAY_MUL;
        return p[12:tpsg_pkg::DECAY_SHIFT];
    endfunction

    // tone periods per attenuation step, minus one
    function automatic logic [5:0] atten_last(input logic [2:0] sel);
        logic [5:0] one;
        one = 6'h01;
        return (one << (sel - 3'h1)) - 6'h01;
    endfunction

    // read value of a register; closed while in module stop
    function automatic logic [31:0] rd_mux(
        input tpsg_pkg::tpsg_state_type st,
        input logic [7:0] addr
    );
        logic [31:0] v;
        v = 32'h00000000;
        if (addr == tpsg_pkg::OFS_MSTOP)
        begin
            v[tpsg_pkg::BIT_MSTOP] = st.mstop;
        end
        else if (!st.mstop)
        begin
            case (addr)
                tpsg_pkg::OFS_CTRL1:
                begin
                    v[tpsg_pkg::BIT_RUN] = st.run_req;
                    v[tpsg_pkg::BIT_STOP_PROCEDURE_SELECT] = st.stop_procedure_select;
                    v[tpsg_pkg::POS_ACS +: 3] = st.acs;
                end
                tpsg_pkg::OFS_CSR:
                begin
                    v[tpsg_pkg::BIT_IRQ_EN] = st.irq_en;
                    v[tpsg_pkg::BIT_DONE] = st.done;
                end
                tpsg_pkg::OFS_CTRL2:
                begin
                    v[tpsg_pkg::BIT_STOP_CONFIRM] = st.stop_confirm;
                    v[tpsg_pkg::BIT_UNLOCK] = st.unlock;
                end
                tpsg_pkg::OFS_DUTY: v[7:0] = st.duty;
                tpsg_pkg::OFS_PITCH: v[7:0] = st.pitch;
                tpsg_pkg::OFS_REFDIV: v[7:0] = st.refdiv;
                default: v = 32'h00000000;
            endcase
        end
        return v;
    endfunction

    always_comb
    begin
        s_next = s_reg;
        ref_tick = 1'b0;
        pitch_tick = 1'b0;
        atk = 1'b0;
        done_evt = 1'b0;
        done_clr = 1'b0;
        a_phase = HSEL_IN && HREADY_IN && HTRANS_IN[1];
        dp_wr = s_reg.dp_valid && s_reg.dp_write;

        // run control from the settled registers
        if (s_reg.mstop)
        begin
            s_next.running = 1'b0;
        end
        else if (s_reg.run_req)
        begin
            s_next.running = 1'b1;
        end
        else if (!s_reg.stop_procedure_select)
        begin
            s_next.running = 1'b0;
        end
        else if (s_reg.acs == tpsg_pkg::ACS_OFF)
        begin
            s_next.running = s_reg.running && !s_reg.stop_confirm;
        end
        else
        begin
            s_next.running = s_reg.running && !s_reg.done;
        end

        // tone dividers and attenuator
        if (s_next.running && !s_reg.running)
        begin
            s_next.ref_cnt = 8'h00;
            s_next.pitch_cnt = 7'h00;
            s_next.tone = 1'b1;
            s_next.atten_cnt = 6'h00;
            s_next.cur_duty = s_reg.duty;
            s_next.suppress = 1'b0;
        end
        else if (s_reg.running)
        begin
            // a zero divider is treated as its largest count
            ref_tick = s_reg.ref_cnt >= s_reg.refdiv - 8'h01;
            s_next.ref_cnt = ref_tick ? 8'h00 : s_reg.ref_cnt + 8'h01;
            if (ref_tick)
            begin
                pitch_tick = s_reg.pitch_cnt >= s_reg.pitch[6:0] - 7'h01;
                s_next.pitch_cnt = pitch_tick ? 7'h00
                    : s_reg.pitch_cnt + 7'h01;
            end
            if (pitch_tick)
            begin
                s_next.tone = !s_reg.tone;
            end
            // a tone period ends on the high-to-low toggle
            if (pitch_tick && s_reg.tone && s_reg.acs != tpsg_pkg::ACS_OFF
                && s_reg.acs <= tpsg_pkg::ACS_MAX)
            begin
                atk = s_reg.atten_cnt >= atten_last(s_reg.acs);
                s_next.atten_cnt = atk ? 6'h00 : s_reg.atten_cnt + 6'h01;
            end
            if (atk)
            begin
                s_next.cur_duty = decay(s_reg.cur_duty);
                if (s_next.cur_duty == 8'h00)
                begin
                    done_evt = 1'b1;
                    // next operation starts again from the loudness value
                    s_next.cur_duty = s_reg.duty;
                end
            end
        end

        // free-running 256-clock pwm period
        s_next.pwm_cnt = s_reg.pwm_cnt + 8'h01;

        // data phase of a write
        if (dp_wr && s_reg.dp_addr == tpsg_pkg::OFS_MSTOP)
        begin
            s_next.mstop = HWDATA_IN[tpsg_pkg::BIT_MSTOP];
        end
        if (dp_wr && !s_reg.mstop)
        begin
            case (s_reg.dp_addr)
                tpsg_pkg::OFS_CTRL1:
                begin
                    s_next.run_req = HWDATA_IN[tpsg_pkg::BIT_RUN];
                    s_next.stop_procedure_select = HWDATA_IN[tpsg_pkg::BIT_STOP_PROCEDURE_SELECT];
                    s_next.acs = HWDATA_IN[tpsg_pkg::POS_ACS +: 3];
                end
                tpsg_pkg::OFS_CSR:
                begin
                    s_next.irq_en = HWDATA_IN[tpsg_pkg::BIT_IRQ_EN];
                    s_next.armed = 1'b0;
                    // zero clears only after a read of one
                    done_clr = s_reg.armed && !HWDATA_IN[tpsg_pkg::BIT_DONE];
                end
                tpsg_pkg::OFS_CTRL2:
                begin
                    s_next.stop_confirm =
                        HWDATA_IN[tpsg_pkg::BIT_STOP_CONFIRM];
                    s_next.unlock = HWDATA_IN[tpsg_pkg::BIT_UNLOCK];
                end
                tpsg_pkg::OFS_DUTY:
                begin
                    s_next.duty = HWDATA_IN[7:0];
                    s_next.cur_duty = HWDATA_IN[7:0];
                    s_next.atten_cnt = 6'h00;
                    done_clr = 1'b1;
                end
                tpsg_pkg::OFS_PITCH:
                begin
                    if (s_reg.unlock)
                    begin
                        s_next.pitch = HWDATA_IN[7:0];
                    end
                end
                tpsg_pkg::OFS_REFDIV:
                begin
                    if (s_reg.unlock)
                    begin
                        s_next.refdiv = HWDATA_IN[7:0];
                    end
                end
                default:
                begin
                    s_next.armed = s_reg.armed;
                end
            endcase
        end

        // done flag: an unsuppressed completion in the clearing cycle wins
        if (done_clr)
        begin
            s_next.done = 1'b0;
            s_next.suppress = 1'b0;
        end
        if (done_evt && !s_reg.suppress)
        begin
            s_next.done = 1'b1;
        end
        if (done_evt && !s_reg.stop_procedure_select)
        begin
            s_next.suppress = 1'b1;
        end

        // address phase; read data sees this cycle's write
        if (a_phase)
        begin
            s_next.dp_valid = 1'b1;
            s_next.dp_write = HWRITE_IN;
            s_next.dp_addr = HADDR_IN[7:0];
            if (!HWRITE_IN)
            begin
                s_next.rdata = rd_mux(s_next, HADDR_IN[7:0]);
                if (HADDR_IN[7:0] == tpsg_pkg::OFS_CSR && s_next.done
                    && !s_next.mstop)
                begin
                    s_next.armed = 1'b1;
                end
            end
        end
        else
        begin
            s_next.dp_valid = 1'b0;
            s_next.dp_write = 1'b0;
        end

        // gated pulse during the high tone half only
        s_next.sound = s_next.running && s_next.tone
            && (s_next.pwm_cnt < s_next.cur_duty);
        s_next.irq = s_next.done && s_next.irq_en;
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            s_reg <= tpsg_pkg::ST_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // zero wait states, so the slave never stalls
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = tpsg_pkg::HRESP_OKAY;
    assign HRDATA_OUT = s_reg.rdata;
    assign SOUND_OUT = s_reg.sound;
    assign ATTEN_IRQ_OUT = s_reg.irq;

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    sound_gated_a: assert property (
        SOUND_OUT |-> s_reg.running && s_reg.tone
            && s_reg.pwm_cnt < s_reg.cur_duty)
        else $error("sound output outside running high half");

    divider_lock_a: assert property (
        dp_wr && !s_reg.unlock && (s_reg.dp_addr == tpsg_pkg::OFS_PITCH
            || s_reg.dp_addr == tpsg_pkg::OFS_REFDIV)
        |=> $stable(s_reg.pitch) && $stable(s_reg.refdiv))
        else $error("divider changed while locked");

    duty_write_a: assert property (
        dp_wr && !s_reg.mstop && s_reg.dp_addr == tpsg_pkg::OFS_DUTY
        |=> s_reg.duty == $past(HWDATA_IN[7:0]))
        else $error("loudness duty not stored");

    run_start_a: assert property (
        s_reg.run_req && !s_reg.mstop |=> s_reg.running)
        else $error("run request did not start generation");

    mode0_stop_a: assert property (
        !s_reg.run_req && !s_reg.stop_procedure_select |=> !s_reg.running && !SOUND_OUT)
        else $error("mode zero did not stop");

    confirm_hold_a: assert property (
        s_reg.acs == tpsg_pkg::ACS_OFF && s_reg.stop_procedure_select && !s_reg.run_req
        && !s_reg.mstop
        |=> s_reg.running == ($past(s_reg.running)
            && !$past(s_reg.stop_confirm)))
        else $error("stop confirm handling wrong");

    atten_hold_a: assert property (
        s_reg.acs != tpsg_pkg::ACS_OFF && s_reg.stop_procedure_select && !s_reg.run_req
        && !s_reg.mstop && !s_reg.done && s_reg.running |=> s_reg.running)
        else $error("stopped before attenuation end");

    decay_step_a: assert property (
        atk && decay(s_reg.cur_duty) != 8'h00 && !dp_wr
        |=> s_reg.cur_duty == decay($past(s_reg.cur_duty)))
        else $error("attenuation step wrong");

    done_set_a: assert property (
        done_evt && !s_reg.suppress |=> s_reg.done ##1 ATTEN_IRQ_OUT
            == (s_reg.irq_en && s_reg.done))
        else $error("completion did not set done flag");

    duty_clear_a: assert property (
        dp_wr && !s_reg.mstop && s_reg.dp_addr == tpsg_pkg::OFS_DUTY
        && !done_evt |=> !s_reg.done)
        else $error("duty write did not clear done flag");

    mstop_idle_a: assert property (
        s_reg.mstop |=> !s_reg.running && !SOUND_OUT)
        else $error("generation during module stop");

endmodule

// file: src/tpsg_pkg.sv
// Purpose: constants and state type of the tone/pwm sound generator
// Assumes: 32-bit ahb-lite register access, one clock
// Notes: offsets are byte addresses of aligned words
package tpsg_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CSR = 8'h04;
    localparam logic [7:0] OFS_CTRL2 = 8'h08;
    localparam logic [7:0] OFS_DUTY = 8'h0C;
    localparam logic [7:0] OFS_PITCH = 8'h10;
    localparam logic [7:0] OFS_REFDIV = 8'h14;
    localparam logic [7:0] OFS_MSTOP = 8'h18;
    // first control register fields
    localparam int BIT_RUN = 0;
    localparam int BIT_STOP_PROCEDURE_SELECT = 1;
    localparam int POS_ACS = 2;
    // control status register fields
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_DONE = 6;
    // second control register fields
    localparam int BIT_STOP_CONFIRM = 7;
    localparam int BIT_UNLOCK = 6;
    // module stop register field
    localparam int BIT_MSTOP = 0;
    // attenuation cycle select codes
    localparam logic [2:0] ACS_OFF = 3'h0;
    localparam logic [2:0] ACS_MAX = 3'h6;
    // decay of 1/32 per attenuation step
    localparam int DECAY_SHIFT = 5;
    localparam logic [12:0] DECAY_MUL = 13'h001F;
    // ahb-lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic mstop;
        logic run_req;
        logic stop_procedure_select;
        logic [2:0] acs;
        logic irq_en;
        logic done;
        logic armed;
        logic suppress;
        logic stop_confirm;
        logic unlock;
        logic [7:0] duty;
        logic [7:0] pitch;
        logic [7:0] refdiv;
        logic running;
        logic [7:0] ref_cnt;
        logic [6:0] pitch_cnt;
        logic tone;
        logic [5:0] atten_cnt;
        logic [7:0] cur_duty;
        logic [7:0] pwm_cnt;
        logic sound;
        logic irq;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
    } tpsg_state_type;

    // module stop is the only field that resets to one
    localparam tpsg_state_type ST_RESET = '{mstop: 1'b1, default: '0};
endpackage

// file: verification/tpsg_transducer.sv
// Purpose: transducer model, integrates energy on the sound pin
// Assumes: bench opens a window of whole pwm periods
// Notes: count clears while the window is shut
`timescale 1ns/1ps
module tpsg_transducer
(
    // clock and pin
    input wire logic clk_in,
    input wire logic sound_in,
    // measuring window
    input wire logic win_in,
    output logic [15:0] high_cnt_out
);
    always_ff @(posedge clk_in)
    begin
        if (!win_in)
            high_cnt_out <= 16'h0000;
        else if (sound_in)
            high_cnt_out <= high_cnt_out + 16'h0001;
    end
endmodule

// file: verification/tone_pwm_sound_generator_tb.sv
// Purpose: self-checking bench for the sound generator
// Assumes: zero-wait slave, pitch 4 and refdiv 2 give a 16-clock tone
// Notes: duties are multiples of 16 so energy is phase independent
`timescale 1ns/1ps
module tone_pwm_sound_generator_tb;
    logic clk;
    logic rst_n;
    logic hsel;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic sound;
    logic irq;
    logic win;
    logic [15:0] high_cnt;
    logic [31:0] exp_q[$];
    logic [31:0] got;
    logic [31:0] e;
    logic [31:0] rd;
    logic [7:0] rnd;
    logic [7:0] duties[3] = '{8'h00, 8'h40, 8'hF0};
    event got_ev;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'h96899504;

    tpsg_sound_gen i_tpsg_sound_gen
    (
        .REF_CLK_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
        .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HREADYOUT_OUT(hready), .HRDATA_OUT(hrdata), .HRESP_OUT(hresp),
        .SOUND_OUT(sound), .ATTEN_IRQ_OUT(irq)
    );

    tpsg_transducer i_tpsg_transducer
    (
        .clk_in(clk), .sound_in(sound), .win_in(win),
        .high_cnt_out(high_cnt)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard, whole run needs well under this
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            finish_test();
        end
    end

    // watcher: oldest note against each result
    always @(got_ev)
    begin
        e = exp_q.pop_front();
        comparisons = comparisons + 1;
        if (got !== e)
        begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, e);
        end
    end

    // note then hand over; the delay keeps two results apart
    task automatic check(input logic [31:0] ex, input logic [31:0] g);
        exp_q.push_back(ex);
        got = g;
        -> got_ev;
        #1;
    endtask

    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= tpsg_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge clk);
        // only the bench timeout ends a stalled wait
        while (hready !== 1'b1)
            @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, rd);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
        ahb(1'b0, a, 32'h00000000, rd);
        check(ex, rd);
        check({31'h0, tpsg_pkg::HRESP_OKAY}, {31'h0, hresp});
    endtask

    // count high clocks over one full pwm period
    task automatic measure(input logic [15:0] ex);
        @(posedge clk);
        win <= 1'b1;
        repeat (256) @(posedge clk);
        win <= 1'b0;
        #1;
        check({16'h0000, ex}, {16'h0000, high_cnt});
    endtask

    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        win = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdc(tpsg_pkg::OFS_MSTOP, 32'h00000001);
        wr(tpsg_pkg::OFS_DUTY, 32'h00000055);
        rdc(tpsg_pkg::OFS_DUTY, 32'h00000000);
        wr(tpsg_pkg::OFS_MSTOP, 32'h00000000);
        rdc(tpsg_pkg::OFS_DUTY, 32'h00000000);
        repeat (4)
        begin
            rnd = 8'($random(seed));
            wr(tpsg_pkg::OFS_DUTY, {24'h000000, rnd});
            rdc(tpsg_pkg::OFS_DUTY, {24'h000000, rnd});
        end
        // divider lock, then unlock
        wr(tpsg_pkg::OFS_PITCH, 32'h00000004);
        rdc(tpsg_pkg::OFS_PITCH, 32'h00000000);
        wr(tpsg_pkg::OFS_CTRL2, 32'h00000040);
        wr(tpsg_pkg::OFS_PITCH, 32'h00000004);
        wr(tpsg_pkg::OFS_REFDIV, 32'h00000002);
        rdc(tpsg_pkg::OFS_PITCH, 32'h00000004);
        rdc(tpsg_pkg::OFS_REFDIV, 32'h00000002);
        rdc(8'h1C, 32'h00000000);
        // config only while stopped
        foreach (duties[k])
        begin
            wr(tpsg_pkg::OFS_CTRL1, 32'h00000000);
            wr(tpsg_pkg::OFS_DUTY, {24'h000000, duties[k]});
            measure(16'h0000);
            wr(tpsg_pkg::OFS_CTRL1, 32'h00000001);
            measure({9'h000, duties[k][7:1]});
        end
        wr(tpsg_pkg::OFS_CTRL1, 32'h00000003);
        wr(tpsg_pkg::OFS_CTRL1, 32'h00000002);
        measure(16'h0078);
        wr(tpsg_pkg::OFS_CTRL2, 32'h000000C0);
        measure(16'h0000);
        wr(tpsg_pkg::OFS_CTRL2, 32'h00000040);
        // 33 decays to zero in 32 steps of one tone period
        wr(tpsg_pkg::OFS_DUTY, 32'h00000021);
        wr(tpsg_pkg::OFS_CSR, 32'h00000080);
        wr(tpsg_pkg::OFS_CTRL1, 32'h00000007);
        wr(tpsg_pkg::OFS_CTRL1, 32'h00000006);
        repeat (200) @(posedge clk);
        rdc(tpsg_pkg::OFS_CSR, 32'h00000080);
        repeat (500) @(posedge clk);
        rdc(tpsg_pkg::OFS_CSR, 32'h000000C0);
        check(32'h00000001, {31'h0, irq});
        measure(16'h0000);
        wr(tpsg_pkg::OFS_CSR, 32'h00000080);
        rdc(tpsg_pkg::OFS_CSR, 32'h00000080);
        check(32'h00000000, {31'h0, irq});
        // mode zero, a step every two tone periods: 32 steps near 1016
        wr(tpsg_pkg::OFS_CTRL1, 32'h00000009);
        repeat (700) @(posedge clk);
        rdc(tpsg_pkg::OFS_CSR, 32'h00000080);
        repeat (400) @(posedge clk);
        rdc(tpsg_pkg::OFS_CSR, 32'h000000C0);
        // clearing mid attenuation re-arms the next completion
        wr(tpsg_pkg::OFS_CSR, 32'h00000080);
        rdc(tpsg_pkg::OFS_CSR, 32'h00000080);
        repeat (1000) @(posedge clk);
        rdc(tpsg_pkg::OFS_CSR, 32'h000000C0);
        wr(tpsg_pkg::OFS_CTRL1, 32'h00000008);
        measure(16'h0000);
        wr(tpsg_pkg::OFS_DUTY, 32'h00000021);
        rdc(tpsg_pkg::OFS_CSR, 32'h00000080);
        finish_test();
    end
endmodule
